// *** common/flash_status_pkg.sv ***
// package for the flash status and fault flag block
package flash_status_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 32;
    // word indices, each register one aligned word on the bus
    localparam logic [ADDR_W-1:0] CMD_STATUS_IDX   = 4'h6;
    localparam logic [ADDR_W-1:0] FAULT_STATUS_IDX = 4'h7;
    // command status bit positions
    localparam int          CCF_BIT         = 7;
    localparam int          AERR_BIT        = 5;
    localparam int          PVIOL_BIT       = 4;
    localparam int          BUSY_BIT        = 3;
    localparam int          CSTAT_LO        = 0;
    // fault status bit positions
    localparam int          DFAULT_BIT      = 1;
    localparam int          SFAULT_BIT      = 0;
    localparam logic [7:0]  ZERO_BYTE       = 8'h00;
    localparam logic [1:0]  CSTAT_CLEAR     = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01
    } ctl_state_t;

    // events reported by the command sequencer and the array read path
    typedef struct packed {
        logic       seq_violation;
        logic       illegal_cmd;
        logic       prot_violation;
        logic       cmd_done;
        logic       cmd_error;
        logic [1:0] cmd_error_code;
        logic       reset_seq_error;
        logic [1:0] reset_seq_code;
        logic       read_double;
        logic       read_single;
        logic       read_busy_block;
    } flash_events_t;

    typedef struct packed {
        logic       command_complete_irq_enable;
        logic       ignore_single_fault;
        logic       double_fault_irq_enable;
        logic       single_fault_irq_enable;
    } flash_config_t;

    typedef struct packed {
        ctl_state_t state;
        logic       command_complete_flag;
        logic       access_error_flag;
        logic       protection_violation_flag;
        logic [1:0] completion_status;
        logic       double_fault_flag;
        logic       single_fault_flag;
        logic       waitreq;
        logic [DATA_W-1:0] rdata;
    } flash_state_t;
endpackage

// *** src/flash_status_error_flags.sv ***
// flash command status and fault status flag logic with avalon slave
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module flash_status_error_flags
    import flash_status_pkg::*;
#(
    parameter int ADDRESS_W = flash_status_pkg::ADDR_W
) (
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    input  wire logic [ADDRESS_W-1:0]          avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [DATA_W-1:0]             avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output logic [DATA_W-1:0]                  avs_readdata,
    output logic                               avs_waitrequest,
    input  wire flash_status_pkg::flash_events_t events,
    input  wire flash_status_pkg::flash_config_t cfg,
    output logic                               cmd_launch,
    output logic                               seq_start_allowed,
    output logic                               cmd_complete_irq,
    output logic                               double_fault_irq,
    output logic                               single_fault_irq
);
    import flash_status_pkg::*;

    initial begin
        if (ADDRESS_W < ADDR_W) begin
            $error("address width too small for register map");
        end
    end

    flash_state_t state_reg;
    flash_state_t state_next;

    logic         wr_cmd;
    logic         wr_fault;
    logic [7:0]   wbyte;

    function automatic logic hit(input logic [ADDRESS_W-1:0] a,
                                 input logic [ADDR_W-1:0] idx);
        hit = (a == ADDRESS_W'(idx));
    endfunction

    function automatic logic [7:0] cmd_byte(input flash_state_t s);
        logic [7:0] b;
        b = ZERO_BYTE;
        b[CCF_BIT]   = s.command_complete_flag;
        b[AERR_BIT]  = s.access_error_flag;
        b[PVIOL_BIT] = s.protection_violation_flag;
        b[BUSY_BIT]  = (s.state == ST_BUSY);
        b[CSTAT_LO +: 2] = s.completion_status;
        cmd_byte = b;
    endfunction

    // one wait state: the access completes on the second cycle
    assign avs_waitrequest = (avs_read | avs_write) & ~state_reg.waitreq;
    assign avs_readdata    = state_reg.rdata;

    assign wbyte    = avs_writedata[7:0];
    assign wr_cmd   = avs_write & ~avs_waitrequest & avs_byteenable[0]
                      & hit(avs_address, CMD_STATUS_IDX);
    assign wr_fault = avs_write & ~avs_waitrequest & avs_byteenable[0]
                      & hit(avs_address, FAULT_STATUS_IDX);

    // a launch needs both error flags clear; otherwise the CCF bit of the write is ignored
    assign cmd_launch = wr_cmd & wbyte[CCF_BIT]
                        & state_reg.command_complete_flag
                        & ~state_reg.access_error_flag
                        & ~state_reg.protection_violation_flag;
    assign seq_start_allowed = ~state_reg.protection_violation_flag;

    assign cmd_complete_irq = state_reg.command_complete_flag
                              & cfg.command_complete_irq_enable;
    assign double_fault_irq = state_reg.double_fault_flag
                              & cfg.double_fault_irq_enable;
    assign single_fault_irq = state_reg.single_fault_flag
                              & cfg.single_fault_irq_enable
                              & ~cfg.ignore_single_fault;

    always_comb begin
        logic ended;
        logic aerr_set;
        logic sfault_set;
        ended = 1'b0;
        aerr_set = 1'b0;
        sfault_set = 1'b0;
        state_next = state_reg;
        state_next.waitreq = (avs_read | avs_write) & ~state_reg.waitreq;

        unique case (state_reg.state)
            ST_IDLE: begin
                if (cmd_launch) begin
                    state_next.state = ST_BUSY;
                    state_next.command_complete_flag = 1'b0;
                    state_next.completion_status = CSTAT_CLEAR;
                end
            end
            ST_BUSY: begin
                ended = events.cmd_done | events.seq_violation
                        | events.illegal_cmd | events.prot_violation;
                if (ended) begin
                    state_next.state = ST_IDLE;
                    state_next.command_complete_flag = 1'b1;
                end
                if (events.cmd_error) begin
                    state_next.completion_status =
                        state_reg.completion_status
                        | events.cmd_error_code;
                end
            end
            default: begin
                state_next.state = ST_IDLE;
            end
        endcase

        // a double fault in the reset sequence raises status after reset
        if (events.reset_seq_error) begin
            state_next.completion_status =
                state_next.completion_status
                | events.reset_seq_code;
        end

        // clears first, so a same-cycle event wins
        if (wr_cmd && wbyte[AERR_BIT]) begin
            state_next.access_error_flag = 1'b0;
        end
        if (wr_cmd && wbyte[PVIOL_BIT]) begin
            state_next.protection_violation_flag = 1'b0;
        end
        if (wr_fault && wbyte[DFAULT_BIT]) begin
            state_next.double_fault_flag = 1'b0;
        end
        if (wr_fault && wbyte[SFAULT_BIT]) begin
            state_next.single_fault_flag = 1'b0;
        end

        aerr_set = events.seq_violation | events.illegal_cmd;
        if (aerr_set) begin
            state_next.access_error_flag = 1'b1;
        end
        if (events.prot_violation) begin
            state_next.protection_violation_flag = 1'b1;
        end
        if (events.read_double || events.read_busy_block) begin
            state_next.double_fault_flag = 1'b1;
        end
        sfault_set = (events.read_single | events.read_busy_block)
                     & ~cfg.ignore_single_fault;
        if (sfault_set) begin
            state_next.single_fault_flag = 1'b1;
        end

        // captured in the wait cycle so data stands at the accepting edge
        state_next.rdata = '0;
        if (avs_read && avs_waitrequest) begin
            if (hit(avs_address, CMD_STATUS_IDX)) begin
                state_next.rdata = {24'h000000, cmd_byte(state_reg)};
            end else if (hit(avs_address, FAULT_STATUS_IDX)) begin
                state_next.rdata[DFAULT_BIT] = state_reg.double_fault_flag;
                state_next.rdata[SFAULT_BIT] = state_reg.single_fault_flag;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= '{state: ST_IDLE, command_complete_flag: 1'b1,
                           default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    property p_launch_clears;
        @(posedge core_clk) disable iff (rst)
        cmd_launch |=> !state_reg.command_complete_flag
                       && state_reg.state == ST_BUSY;
    endproperty
    a_launch_clears: assert property (p_launch_clears)
        else $error("launch did not clear complete flag");

    property p_complete_on_done;
        @(posedge core_clk) disable iff (rst)
        (state_reg.state == ST_BUSY && events.cmd_done)
            |=> state_reg.command_complete_flag;
    endproperty
    a_complete_on_done: assert property (p_complete_on_done)
        else $error("complete flag not set after command end");

    property p_aerr_set;
        @(posedge core_clk) disable iff (rst)
        (events.seq_violation || events.illegal_cmd)
            |=> state_reg.access_error_flag;
    endproperty
    a_aerr_set: assert property (p_aerr_set)
        else $error("access error flag not set");

    property p_no_launch_on_err;
        @(posedge core_clk) disable iff (rst)
        (state_reg.access_error_flag || state_reg.protection_violation_flag)
            |-> !cmd_launch;
    endproperty
    a_no_launch_on_err: assert property (p_no_launch_on_err)
        else $error("launch while error flag set");

    property p_aerr_sticky;
        @(posedge core_clk) disable iff (rst)
        (state_reg.access_error_flag && !(wr_cmd && wbyte[AERR_BIT]))
            |=> state_reg.access_error_flag;
    endproperty
    a_aerr_sticky: assert property (p_aerr_sticky)
        else $error("access error flag lost without clear");

    property p_pviol_sticky;
        @(posedge core_clk) disable iff (rst)
        (state_reg.protection_violation_flag
            && !(wr_cmd && wbyte[PVIOL_BIT]))
            |=> state_reg.protection_violation_flag;
    endproperty
    a_pviol_sticky: assert property (p_pviol_sticky)
        else $error("protection flag lost without clear");

    property p_busy_matches;
        @(posedge core_clk) disable iff (rst)
        (state_reg.state == ST_BUSY) == !state_reg.command_complete_flag;
    endproperty
    a_busy_matches: assert property (p_busy_matches)
        else $error("busy and complete flag disagree");

    property p_dfault_set;
        @(posedge core_clk) disable iff (rst)
        (events.read_double || events.read_busy_block)
            |=> state_reg.double_fault_flag;
    endproperty
    a_dfault_set: assert property (p_dfault_set)
        else $error("double fault flag not set");

    property p_sfault_ignored;
        @(posedge core_clk) disable iff (rst)
        (cfg.ignore_single_fault && !state_reg.single_fault_flag)
            |=> !state_reg.single_fault_flag || !$past(cfg.ignore_single_fault);
    endproperty
    a_sfault_ignored: assert property (p_sfault_ignored)
        else $error("single fault reported while ignored");

    property p_dfault_sticky;
        @(posedge core_clk) disable iff (rst)
        (state_reg.double_fault_flag && !(wr_fault && wbyte[DFAULT_BIT]))
            |=> state_reg.double_fault_flag;
    endproperty
    a_dfault_sticky: assert property (p_dfault_sticky)
        else $error("double fault flag lost without clear");

    property p_pviol_set;
        @(posedge core_clk) disable iff (rst)
        events.prot_violation |=> state_reg.protection_violation_flag;
    endproperty
    a_pviol_set: assert property (p_pviol_set)
        else $error("protection flag not set");

    property p_aerr_clear;
        @(posedge core_clk) disable iff (rst)
        (wr_cmd && wbyte[AERR_BIT]
            && !(events.seq_violation || events.illegal_cmd))
            |=> !state_reg.access_error_flag;
    endproperty
    a_aerr_clear: assert property (p_aerr_clear)
        else $error("access error flag not cleared");

    property p_pviol_clear;
        @(posedge core_clk) disable iff (rst)
        (wr_cmd && wbyte[PVIOL_BIT] && !events.prot_violation)
            |=> !state_reg.protection_violation_flag;
    endproperty
    a_pviol_clear: assert property (p_pviol_clear)
        else $error("protection flag not cleared");

    property p_dfault_clear;
        @(posedge core_clk) disable iff (rst)
        (wr_fault && wbyte[DFAULT_BIT]
            && !(events.read_double || events.read_busy_block))
            |=> !state_reg.double_fault_flag;
    endproperty
    a_dfault_clear: assert property (p_dfault_clear)
        else $error("double fault flag not cleared");

    property p_sfault_clear;
        @(posedge core_clk) disable iff (rst)
        (wr_fault && wbyte[SFAULT_BIT]
            && !(events.read_single || events.read_busy_block))
            |=> !state_reg.single_fault_flag;
    endproperty
    a_sfault_clear: assert property (p_sfault_clear)
        else $error("single fault flag not cleared");

    property p_sfault_set;
        @(posedge core_clk) disable iff (rst)
        ((events.read_single || events.read_busy_block)
            && !cfg.ignore_single_fault)
            |=> state_reg.single_fault_flag;
    endproperty
    a_sfault_set: assert property (p_sfault_set)
        else $error("single fault flag not set");

    property p_sfault_sticky;
        @(posedge core_clk) disable iff (rst)
        (state_reg.single_fault_flag && !(wr_fault && wbyte[SFAULT_BIT]))
            |=> state_reg.single_fault_flag;
    endproperty
    a_sfault_sticky: assert property (p_sfault_sticky)
        else $error("single fault flag lost without clear");

    property p_complete_held;
        @(posedge core_clk) disable iff (rst)
        (!state_reg.command_complete_flag
            && !(events.cmd_done || events.seq_violation
                 || events.illegal_cmd || events.prot_violation))
            |=> !state_reg.command_complete_flag;
    endproperty
    a_complete_held: assert property (p_complete_held)
        else $error("complete flag rose before command end");

    property p_cstat_launch;
        @(posedge core_clk) disable iff (rst)
        (cmd_launch && !events.reset_seq_error)
            |=> state_reg.completion_status == CSTAT_CLEAR;
    endproperty
    a_cstat_launch: assert property (p_cstat_launch)
        else $error("completion status not cleared at launch");

    property p_busy_readback;
        @(posedge core_clk) disable iff (rst)
        (avs_read && !avs_waitrequest && hit(avs_address, CMD_STATUS_IDX))
            |-> avs_readdata[BUSY_BIT] != avs_readdata[CCF_BIT];
    endproperty
    a_busy_readback: assert property (p_busy_readback)
        else $error("busy bit read back equal to complete flag");

    property p_unmapped_zero;
        @(posedge core_clk) disable iff (rst)
        (avs_read && !avs_waitrequest
            && !hit(avs_address, CMD_STATUS_IDX)
            && !hit(avs_address, FAULT_STATUS_IDX))
            |-> avs_readdata == '0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read returned nonzero data");

    property p_one_wait;
        @(posedge core_clk) disable iff (rst)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("more than one wait state");
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking testbench for the flash status and fault flag block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import flash_status_pkg::*;
    logic                 core_clk = 1'b0;
    logic                 rst = 1'b1;
    logic [ADDR_W-1:0]    avs_address = '0;
    logic                 avs_read = 1'b0;
    logic                 avs_write = 1'b0;
    logic [DATA_W-1:0]    avs_writedata = '0;
    logic [3:0]           avs_byteenable = 4'h0;
    logic [DATA_W-1:0]    avs_readdata;
    logic                 avs_waitrequest;
    flash_events_t        ev = '0;
    flash_config_t        cfg = '0;
    logic                 cmd_launch;
    logic                 seq_start_allowed;
    logic                 cmd_complete_irq;
    logic                 double_fault_irq;
    logic                 single_fault_irq;
    logic                 launch_seen;
    int                   bad_count = 0;
    int                   n_compared = 0;
    int                   cycles = 0;

    flash_status_error_flags flash_status_error_flags_i (
        .core_clk          (core_clk),
        .rst               (rst),
        .avs_address       (avs_address),
        .avs_read          (avs_read),
        .avs_write         (avs_write),
        .avs_writedata     (avs_writedata),
        .avs_byteenable    (avs_byteenable),
        .avs_readdata      (avs_readdata),
        .avs_waitrequest   (avs_waitrequest),
        .events            (ev),
        .cfg               (cfg),
        .cmd_launch        (cmd_launch),
        .seq_start_allowed (seq_start_allowed),
        .cmd_complete_irq  (cmd_complete_irq),
        .double_fault_irq  (double_fault_irq),
        .single_fault_irq  (single_fault_irq)
    );

    always #2 core_clk = ~core_clk;

    task automatic complete_run;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // a hang costs far more than the roughly 160 cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // request held until the edge that sees waitrequest low; one idle edge
    // after release keeps back-to-back calls from re-driving a strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] be = 4'h1);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        launch_seen = cmd_launch;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    // read data stands at the accepting edge and is taken there
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp,
                        input string name);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        check(name, avs_readdata[7:0], exp);
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic pulse(input flash_events_t p);
        ev <= p;
        @(posedge core_clk);
        ev <= '0;
        @(posedge core_clk);
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rchk(4'h6, 8'h80, "cmd status reset");
        rchk(4'h7, 8'h00, "fault status reset");
        rchk(4'h0, 8'h00, "unmapped read");
        $display("test reset done");
        wr(4'h6, 8'h80);
        check("launch", {7'h00, launch_seen}, 8'h01);
        rchk(4'h6, 8'h08, "busy after launch");
        pulse('{cmd_done: 1'b1, cmd_error: 1'b1, cmd_error_code: 2'h2,
                default: '0});
        rchk(4'h6, 8'h82, "done with error");
        wr(4'h6, 8'h80, 4'h0);
        check("launch lane off", {7'h00, launch_seen}, 8'h00);
        $display("test launch done");
        pulse('{illegal_cmd: 1'b1, default: '0});
        rchk(4'h6, 8'hA2, "access error set");
        wr(4'h6, 8'h80);
        check("launch blocked", {7'h00, launch_seen}, 8'h00);
        rchk(4'h6, 8'hA2, "complete kept");
        wr(4'h6, 8'h00);
        rchk(4'h6, 8'hA2, "error write 0");
        wr(4'h6, 8'h20);
        rchk(4'h6, 8'h82, "error cleared");
        wr(4'h6, 8'h80);
        pulse('{seq_violation: 1'b1, default: '0});
        rchk(4'h6, 8'hA0, "violation ends cmd");
        wr(4'h6, 8'h20);
        $display("test access error done");
        pulse('{prot_violation: 1'b1, default: '0});
        rchk(4'h6, 8'h90, "protection set");
        check("seq start off", {7'h00, seq_start_allowed}, 8'h00);
        wr(4'h6, 8'h80);
        check("launch prot", {7'h00, launch_seen}, 8'h00);
        wr(4'h6, 8'h00);
        rchk(4'h6, 8'h90, "protection write 0");
        wr(4'h6, 8'h10);
        rchk(4'h6, 8'h80, "protection cleared");
        check("seq start on", {7'h00, seq_start_allowed}, 8'h01);
        wr(4'h6, 8'hFF);
        check("launch all ones", {7'h00, launch_seen}, 8'h01);
        rchk(4'h6, 8'h08, "reserved bits");
        pulse('{cmd_done: 1'b1, default: '0});
        pulse('{reset_seq_error: 1'b1, reset_seq_code: 2'h1, default: '0});
        rchk(4'h6, 8'h81, "reset sequence status");
        $display("test protection done");
        cfg <= '{1'b1, 1'b0, 1'b1, 1'b1};
        @(posedge core_clk);
        check("complete irq", {7'h00, cmd_complete_irq}, 8'h01);
        pulse('{read_double: 1'b1, default: '0});
        rchk(4'h7, 8'h02, "double fault");
        check("double irq", {7'h00, double_fault_irq}, 8'h01);
        wr(4'h7, 8'h00);
        rchk(4'h7, 8'h02, "double write 0");
        wr(4'h7, 8'h02);
        rchk(4'h7, 8'h00, "double cleared");
        check("double irq off", {7'h00, double_fault_irq}, 8'h00);
        pulse('{read_single: 1'b1, default: '0});
        rchk(4'h7, 8'h01, "single fault");
        check("single irq", {7'h00, single_fault_irq}, 8'h01);
        wr(4'h7, 8'h00);
        rchk(4'h7, 8'h01, "single write 0");
        cfg <= '{1'b0, 1'b1, 1'b1, 1'b1};
        @(posedge core_clk);
        check("complete irq off", {7'h00, cmd_complete_irq}, 8'h00);
        check("single irq masked", {7'h00, single_fault_irq}, 8'h00);
        wr(4'h7, 8'h01);
        pulse('{read_single: 1'b1, default: '0});
        rchk(4'h7, 8'h00, "single ignored");
        check("single irq ignored", {7'h00, single_fault_irq}, 8'h00);
        cfg <= '{1'b0, 1'b0, 1'b1, 1'b1};
        @(posedge core_clk);
        pulse('{read_busy_block: 1'b1, default: '0});
        rchk(4'h7, 8'h03, "busy block read");
        wr(4'h7, 8'h03);
        rchk(4'h7, 8'h00, "faults cleared");
        $display("test faults done");
        complete_run();
    end
endmodule
`default_nettype wire
